// ===== logic/line_pkg.sv
// shared constants, types and code tables for the line coding datapath
package line_pkg;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
  localparam int CLK_NS = 10;
  localparam int SER_BIT_MHZ = 125;
  localparam int MAN_BIT_NS = 100;
  localparam int MAN_BIT_CYC = MAN_BIT_NS / CLK_NS;
  localparam int MAN_SKIP_CYC = (MAN_BIT_CYC * 3) / 4;
  localparam int MAN_IDLE_CYC = 2 * MAN_BIT_CYC;
  localparam logic [4:0] MAN_SKIP = 5'(MAN_SKIP_CYC);
  localparam logic [4:0] MAN_IDLE = 5'(MAN_IDLE_CYC);
  localparam logic [4:0] MAN_HALF = 5'(MAN_BIT_CYC / 2);
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  localparam logic [3:0] LOCK_BITS = 4'hB;
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_SFD_HI = 4'hD;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam int PREAMBLE_BYTES = 7;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_NEG = 2'h3;

  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h00;
    unique case (n)
      4'h0: c = 5'h1E; 4'h1: c = 5'h09; 4'h2: c = 5'h14; 4'h3: c = 5'h15;
      4'h4: c = 5'h0A; 4'h5: c = 5'h0B; 4'h6: c = 5'h0E; 4'h7: c = 5'h0F;
      4'h8: c = 5'h12; 4'h9: c = 5'h13; 4'hA: c = 5'h16; 4'hB: c = 5'h17;
      4'hC: c = 5'h1A; 4'hD: c = 5'h1B; 4'hE: c = 5'h1C; 4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction

  // returns {invalid, nibble}
  function automatic logic [4:0] dec_5b4b(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h10;
    case (c)
      5'h1E: r = 5'h00; 5'h09: r = 5'h01; 5'h14: r = 5'h02; 5'h15: r = 5'h03;
      5'h0A: r = 5'h04; 5'h0B: r = 5'h05; 5'h0E: r = 5'h06; 5'h0F: r = 5'h07;
      5'h12: r = 5'h08; 5'h13: r = 5'h09; 5'h16: r = 5'h0A; 5'h17: r = 5'h0B;
      5'h1A: r = 5'h0C; 5'h1B: r = 5'h0D; 5'h1C: r = 5'h0E; 5'h1D: r = 5'h0F;
      default: r = 5'h10;
    endcase
    return r;
  endfunction
endpackage

// ===== logic/lfsr_scrambler.sv
// 11-bit additive scrambler / descrambler with key loading
`timescale 1ns/1ps
module lfsr_scrambler (
  input wire logic clock,
  input wire logic rst,
  input wire logic bit_in,
  input wire logic load_en,
  input wire logic load_bit,
  output logic bit_out
);
  import line_pkg::*;
  logic [LFSR_W-1:0] lfsr_q;
  logic key;

  assign key = lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B];
  assign bit_out = bit_in ^ key;

  // x^11 + x^9 + 1, 2047-state sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[LFSR_W-2:0], load_en ? load_bit : key};
    end
  end

  a_lfsr_nonzero: assert property (@(posedge clock) disable iff (rst)
    !load_en |=> lfsr_q != '0) else $error("scrambler state stuck at zero");
endmodule // lfsr_scrambler

// ===== logic/manchester_rx.sv
// manchester decoder with free running receive clock
`timescale 1ns/1ps
module manchester_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic line_in,
  output logic bit_q,
  output logic bit_valid_q,
  output logic active_q,
  output logic rx_clk_q
);
  import line_pkg::*;
  logic prev_q;
  logic [4:0] since_q;
  logic [4:0] div_q;
  logic edge_seen;

  assign edge_seen = line_in != prev_q;

  // mid-bit edge gives data, boundary edges ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      since_q <= MAN_IDLE;
      bit_q <= 1'b0;
      bit_valid_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      prev_q <= line_in;
      bit_valid_q <= 1'b0;
      if (edge_seen && since_q >= MAN_SKIP) begin
        bit_q <= line_in;
        bit_valid_q <= 1'b1;
        active_q <= 1'b1;
        since_q <= '0;
      end else if (since_q != MAN_IDLE) begin
        since_q <= since_q + 5'h01;
      end else begin
        active_q <= 1'b0;
      end
    end
  end

  // clock toward the mac runs through idle gaps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      rx_clk_q <= 1'b0;
    end else if (div_q == MAN_HALF - 5'h01) begin
      div_q <= '0;
      rx_clk_q <= ~rx_clk_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end
endmodule // manchester_rx

// ===== logic/line_coding_top.sv
// 10/100 line coding datapath and speed dependent controls
`timescale 1ns/1ps
module line_coding_top (
  input wire logic clock,
  input wire logic rst,
  input line_pkg::speed_t speed,
  input wire logic rgmii_mode,
  input wire logic gig_slave,
  input wire logic ldo_disable,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic tx_ready,
  output logic [1:0] tx_mlt3,
  input wire logic [1:0] rx_mlt3,
  input wire logic rx10_line,
  output logic [7:0] rxd,
  output logic rx_dv,
  output logic rx_clk,
  output logic tx_clk_from_rx,
  output logic hybrid_en,
  output logic adc_en,
  output logic ldo_ctrl_en
);
  import line_pkg::*;

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;
  typedef enum {RX_IDLE, RX_DATA} rx_state_t;
  typedef enum {R10_HUNT, R10_SFD_HI, R10_DATA} r10_state_t;

  logic is100;
  assign is100 = speed == SPD_100;

  // static controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hybrid_en <= 1'b0;
      adc_en <= 1'b0;
      tx_clk_from_rx <= 1'b0;
      ldo_ctrl_en <= 1'b1;
    end else begin
      hybrid_en <= speed == SPD_1000;
      adc_en <= speed == SPD_1000;
      tx_clk_from_rx <= speed == SPD_1000 && gig_slave;
      ldo_ctrl_en <= ~ldo_disable;
    end
  end

  // ---------------- 100M transmit
  tx_state_t tx_state_q;
  logic [2:0] tx_cnt_q;
  logic [4:0] tx_sh_q;
  logic [4:0] tx_grp_d;
  tx_state_t tx_state_d;
  logic tx_load;
  logic scr_bit;
  logic nrzi_q;
  logic nrzi_prev_q;
  logic mlt_down_q;
  logic [1:0] mlt3_q;

  assign tx_load = tx_cnt_q == GRP_LAST;
  assign tx_ready = tx_load && is100;

  always_comb begin
    tx_grp_d = CG_IDLE;
    tx_state_d = tx_state_q;
    unique case (tx_state_q)
      TX_IDLE: begin
        if (tx_en) begin
          tx_grp_d = CG_J;
          tx_state_d = TX_K;
        end
      end
      TX_K: begin
        tx_grp_d = CG_K;
        tx_state_d = TX_DATA;
      end
      TX_DATA: begin
        if (tx_en) begin
          tx_grp_d = enc_4b5b(txd);
        end else begin
          tx_grp_d = CG_T;
          tx_state_d = TX_R;
        end
      end
      TX_R: begin
        tx_grp_d = CG_R;
        tx_state_d = TX_IDLE;
      end
    endcase
  end

  // serialiser, one line bit per clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_cnt_q <= '0;
      tx_sh_q <= CG_IDLE;
      tx_state_q <= TX_IDLE;
    end else if (!is100) begin
      tx_cnt_q <= '0;
      tx_sh_q <= CG_IDLE;
      tx_state_q <= TX_IDLE;
    end else if (tx_load) begin
      tx_cnt_q <= '0;
      tx_sh_q <= tx_grp_d;
      tx_state_q <= tx_state_d;
    end else begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
      tx_sh_q <= {tx_sh_q[3:0], 1'b0};
    end
  end

  lfsr_scrambler u_scr (
    .clock(clock),
    .rst(rst),
    .bit_in(tx_sh_q[4]),
    .load_en(1'b0),
    .load_bit(1'b0),
    .bit_out(scr_bit)
  );

  // nrzi then mlt-3
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nrzi_q <= 1'b0;
      nrzi_prev_q <= 1'b0;
      mlt3_q <= MLT_ZERO;
      mlt_down_q <= 1'b0;
    end else begin
      nrzi_q <= nrzi_q ^ (scr_bit && is100);
      nrzi_prev_q <= nrzi_q;
      if (!is100) begin
        mlt3_q <= MLT_ZERO;
      end else if (nrzi_q != nrzi_prev_q) begin
        unique case (mlt3_q)
          MLT_POS: begin
            mlt3_q <= MLT_ZERO;
            mlt_down_q <= 1'b1;
          end
          MLT_NEG: begin
            mlt3_q <= MLT_ZERO;
            mlt_down_q <= 1'b0;
          end
          default: mlt3_q <= mlt_down_q ? MLT_NEG : MLT_POS;
        endcase
      end
    end
  end
  assign tx_mlt3 = mlt3_q;

  // ---------------- 100M receive
  logic [1:0] rxm_s1_q;
  logic [1:0] rxm_s2_q;
  logic [1:0] rxm_prev_q;
  logic rx_nrzi_q;
  logic rx_nrzi_prev_q;
  logic rx_lock_q;
  logic rx_rec_clk_q;
  logic rx_nrz;
  logic dscr_bit;
  logic [3:0] dlock_cnt_q;
  logic dscr_load;
  rx_state_t rx_state_q;
  logic [9:0] rx_grp_q;
  logic [2:0] rx_cnt_q;
  logic [4:0] rx_cg;
  logic [4:0] rx_dec;
  logic [3:0] rx100_nib_q;
  logic rx100_dv_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxm_s1_q <= MLT_ZERO;
      rxm_s2_q <= MLT_ZERO;
    end else begin
      rxm_s1_q <= rx_mlt3;
      rxm_s2_q <= rxm_s1_q;
    end
  end

  // level change means one, receive clock toggles every cycle once a transition sets lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxm_prev_q <= MLT_ZERO;
      rx_nrzi_q <= 1'b0;
      rx_nrzi_prev_q <= 1'b0;
      rx_lock_q <= 1'b0;
      rx_rec_clk_q <= 1'b0;
    end else begin
      rxm_prev_q <= rxm_s2_q;
      rx_nrzi_q <= rx_nrzi_q ^ (rxm_s2_q != rxm_prev_q);
      rx_nrzi_prev_q <= rx_nrzi_q;
      if (!is100) begin
        rx_lock_q <= 1'b0;
      end else if (rx_nrzi_q != rx_nrzi_prev_q) begin
        rx_lock_q <= 1'b1;
      end
      rx_rec_clk_q <= rx_lock_q & ~rx_rec_clk_q;
    end
  end
  assign rx_nrz = rx_nrzi_q ^ rx_nrzi_prev_q;

  // descrambler keyed from idle, then free running
  assign dscr_load = dlock_cnt_q != LOCK_BITS;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dlock_cnt_q <= '0;
    end else if (!rx_lock_q) begin
      dlock_cnt_q <= '0;
    end else if (dscr_load) begin
      dlock_cnt_q <= dlock_cnt_q + 4'h1;
    end
  end

  lfsr_scrambler u_dscr (
    .clock(clock),
    .rst(rst),
    .bit_in(rx_nrz),
    .load_en(dscr_load),
    .load_bit(~rx_nrz),
    .bit_out(dscr_bit)
  );

  assign rx_cg = {rx_grp_q[3:0], dscr_bit};
  assign rx_dec = dec_5b4b(rx_cg);

  // code group alignment and deserialiser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_grp_q <= '0;
      rx_cnt_q <= '0;
      rx_state_q <= RX_IDLE;
      rx100_nib_q <= '0;
      rx100_dv_q <= 1'b0;
    end else if (dscr_load) begin
      rx_grp_q <= '0;
      rx_state_q <= RX_IDLE;
      rx100_dv_q <= 1'b0;
    end else begin
      rx_grp_q <= {rx_grp_q[8:0], dscr_bit};
      unique case (rx_state_q)
        RX_IDLE: begin
          if ({rx_grp_q[8:0], dscr_bit} == {CG_J, CG_K}) begin
            rx_state_q <= RX_DATA;
            rx_cnt_q <= '0;
            rx100_nib_q <= NIB_PRE;
            rx100_dv_q <= 1'b1;
          end
        end
        RX_DATA: begin
          rx_cnt_q <= (rx_cnt_q == GRP_LAST) ? 3'h0 : rx_cnt_q + 3'h1;
          if (rx_cnt_q == GRP_LAST) begin
            if (rx_cg == CG_T || rx_dec[4]) begin
              rx_state_q <= RX_IDLE;
              rx100_dv_q <= 1'b0;
            end else begin
              rx100_nib_q <= rx_dec[3:0];
            end
          end
        end
      endcase
    end
  end

  // ---------------- 10M receive
  logic r10_s1_q;
  logic r10_s2_q;
  logic man_bit;
  logic man_valid;
  logic man_active;
  logic man_clk;
  logic pol_inv_q;
  logic [7:0] r10_sh_q;
  logic [7:0] r10_sh_d;
  logic [1:0] r10_bits_q;
  logic [3:0] rx10_nib_q;
  logic rx10_dv_q;
  r10_state_t r10_state_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r10_s1_q <= 1'b0;
      r10_s2_q <= 1'b0;
    end else begin
      r10_s1_q <= rx10_line;
      r10_s2_q <= r10_s1_q;
    end
  end

  manchester_rx u_man (
    .clock(clock),
    .rst(rst),
    .line_in(r10_s2_q),
    .bit_q(man_bit),
    .bit_valid_q(man_valid),
    .active_q(man_active),
    .rx_clk_q(man_clk)
  );

  assign r10_sh_d = {man_bit, r10_sh_q[7:1]};

  // preamble strip, sfd alignment, polarity
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r10_sh_q <= '0;
      r10_bits_q <= '0;
      pol_inv_q <= 1'b0;
      rx10_nib_q <= '0;
      rx10_dv_q <= 1'b0;
      r10_state_q <= R10_HUNT;
    end else if (!man_active) begin
      r10_sh_q <= '0;
      rx10_dv_q <= 1'b0;
      r10_state_q <= R10_HUNT;
    end else begin
      if (man_valid) begin
        r10_sh_q <= r10_sh_d;
      end
      unique case (r10_state_q)
        R10_HUNT: begin
          if (man_valid && (r10_sh_d == SFD_BYTE || r10_sh_d == ~SFD_BYTE)) begin
            pol_inv_q <= r10_sh_d != SFD_BYTE;
            rx10_nib_q <= NIB_PRE;
            rx10_dv_q <= 1'b1;
            r10_state_q <= R10_SFD_HI;
          end
        end
        R10_SFD_HI: begin
          rx10_nib_q <= NIB_SFD_HI;
          r10_bits_q <= '0;
          r10_state_q <= R10_DATA;
        end
        R10_DATA: begin
          if (man_valid) begin
            r10_bits_q <= r10_bits_q + 2'h1;
            if (r10_bits_q == 2'h3) begin
              rx10_nib_q <= r10_sh_d[7:4] ^ {4{pol_inv_q}};
            end
          end
        end
      endcase
    end
  end

  // ---------------- mac side format
  logic [3:0] nib_sel;
  assign nib_sel = is100 ? rx100_nib_q : rx10_nib_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_clk <= 1'b0;
    end else begin
      rxd <= rgmii_mode ? {nib_sel, nib_sel} : {4'h0, nib_sel};
      rx_dv <= is100 ? rx100_dv_q : (speed == SPD_10 && rx10_dv_q);
      rx_clk <= is100 ? rx_rec_clk_q : man_clk;
    end
  end

  // ---------------- checks
  sequence s_j_sent;
    tx_load && tx_state_q == TX_IDLE && tx_en && is100;
  endsequence
  sequence s_k_next;
    ##5 tx_sh_q == CG_K;
  endsequence

  a_jk_start: assert property (@(posedge clock) disable iff (rst)
    s_j_sent |-> ##1 tx_sh_q == CG_J ##0 s_k_next) else $error("J then K not sent");
  a_ready_spacing: assert property (@(posedge clock) disable iff (rst)
    tx_ready |=> !tx_ready [*4]) else $error("nibble taken faster than five bits");
  a_nrzi_toggle: assert property (@(posedge clock) disable iff (rst)
    (scr_bit && is100) |=> nrzi_q != $past(nrzi_q)) else $error("nrzi missed a one");
  a_mlt3_step: assert property (@(posedge clock) disable iff (rst)
    (is100 && nrzi_q != nrzi_prev_q) |=> mlt3_q != $past(mlt3_q)) else $error("mlt-3 did not step");
  a_line_quiet: assert property (@(posedge clock) disable iff (rst)
    !is100 |=> tx_mlt3 == MLT_ZERO) else $error("line driven outside 100M");
  a_analog_off: assert property (@(posedge clock) disable iff (rst)
    speed != SPD_1000 |=> !hybrid_en && !adc_en) else $error("hybrid or adc on below 1000M");
  a_slave_timing: assert property (@(posedge clock) disable iff (rst)
    speed == SPD_1000 && gig_slave |=> tx_clk_from_rx) else $error("slave not timed from rx");
  a_ldo_off: assert property (@(posedge clock) disable iff (rst)
    ldo_disable |=> !ldo_ctrl_en) else $error("regulator controller still on");
  a_sfd_first: assert property (@(posedge clock) disable iff (rst)
    $rose(rx10_dv_q) |-> rx10_nib_q == NIB_PRE ##1 rx10_nib_q == NIB_SFD_HI) else $error("frame not at sfd");
  a_rx_format: assert property (@(posedge clock) disable iff (rst)
    rgmii_mode |=> rxd[7:4] == rxd[3:0]) else $error("rgmii lanes differ");
endmodule // line_coding_top

// ===== testbench/link_partner.sv
// link partner model: cable loopback at 100M, manchester frame source at 10M
`timescale 1ns/1ps
module link_partner (
  input wire logic clock,
  input wire logic [1:0] tx_mlt3,
  output logic [1:0] rx_mlt3,
  output logic rx10_line,
  output logic probe
);
  initial begin
    rx_mlt3 = 2'h0;
    rx10_line = 1'b0;
    probe = 1'b0;
  end

  // cable echoes our own line half a cycle later
  always @(negedge clock) begin
    rx_mlt3 <= tx_mlt3;
  end

  // one half symbol, five cycles; mark pulses probe mid-way
  task automatic half(input logic lvl, input logic mark);
    for (int c = 0; c < 5; c++) begin
      @(negedge clock);
      rx10_line <= lvl;
      probe <= mark && (c == 2);
    end
  endtask

  // seven preamble bytes, delimiter, four data bytes, lsb first
  task automatic send10(input logic [31:0] data, input logic inv);
    logic [95:0] bits;
    logic b;
    bits = {data, 8'hD5, {7{8'h55}}};
    for (int k = 0; k < 96; k++) begin
      b = bits[k] ^ inv;
      half(~b, 1'b0);
      half(b, (k >= 64) && (k % 4 == 0));
    end
    half(bits[95] ^ inv, 1'b0);
    half(bits[95] ^ inv, 1'b1);
    repeat (40) @(negedge clock);
  endtask
endmodule // link_partner

// ===== testbench/tb_top.sv
// self-checking bench for the 10/100 line coding datapath
`timescale 1ns/1ps
module tb_top;
  import line_pkg::*;
  logic clock = 1'b0, rst, rgmii_mode, gig_slave, ldo_disable, tx_en, tx_ready, rx10_line, rx_dv, rx_clk;
  logic tx_clk_from_rx, hybrid_en, adc_en, ldo_ctrl_en, probe, prev_dv, mlt_on;
  speed_t speed;
  logic [3:0] txd;
  logic [1:0] tx_mlt3, rx_mlt3, last_lvl, last_nz;
  logic [7:0] rxd;
  logic [31:0] d;
  logic [3:0] exp_q[$];
  int err_count, checked, cyc, dv_cnt, n;

  line_coding_top line_coding_top_i (.clock(clock), .rst(rst), .speed(speed), .rgmii_mode(rgmii_mode),
    .gig_slave(gig_slave), .ldo_disable(ldo_disable), .tx_en(tx_en), .txd(txd), .tx_ready(tx_ready),
    .tx_mlt3(tx_mlt3), .rx_mlt3(rx_mlt3), .rx10_line(rx10_line), .rxd(rxd), .rx_dv(rx_dv),
    .rx_clk(rx_clk), .tx_clk_from_rx(tx_clk_from_rx), .hybrid_en(hybrid_en), .adc_en(adc_en),
    .ldo_ctrl_en(ldo_ctrl_en));

  link_partner link_partner_i (.clock(clock), .tx_mlt3(tx_mlt3), .rx_mlt3(rx_mlt3),
    .rx10_line(rx10_line), .probe(probe));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_rxd(input logic [3:0] nib);
    return rgmii_mode ? {nib, nib} : {4'h0, nib};
  endfunction

  // next mlt-3 level after a step from lvl, nz being the last non-zero level
  function automatic logic [7:0] exp_mlt(input logic [1:0] lvl, input logic [1:0] nz);
    if (lvl != MLT_ZERO) begin
      return {6'h00, MLT_ZERO};
    end
    return nz == MLT_POS ? {6'h00, MLT_NEG} : {6'h00, MLT_POS};
  endfunction

  task automatic take();
    if (exp_q.size() == 0) begin
      check(8'h01, 8'h00, "extra nibble");
    end else begin
      check(rxd, exp_rxd(exp_q.pop_front()), "nibble");
    end
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  // receive sampling and line level watch
  always @(negedge clock) begin
    if (rst) begin
      prev_dv <= 1'b0;
      dv_cnt <= 0;
      last_lvl <= MLT_ZERO;
      last_nz <= MLT_NEG;
    end else begin
      prev_dv <= rx_dv;
      dv_cnt <= rx_dv ? dv_cnt + 1 : 0;
      if (rx_dv && !prev_dv) begin
        check(rxd, exp_rxd(NIB_PRE), "frame start");
      end else if (rx_dv && speed == SPD_100 && dv_cnt >= 7 && dv_cnt % 5 == 2) begin
        take();
      end
      if (probe) begin
        take();
      end
      if (mlt_on && tx_mlt3 !== last_lvl) begin
        check({6'h00, tx_mlt3}, exp_mlt(last_lvl, last_nz), "mlt3 step");
        last_lvl <= tx_mlt3;
        if (tx_mlt3 != MLT_ZERO) begin
          last_nz <= tx_mlt3;
        end
      end
    end
  end

  task automatic send100(input int cnt);
    logic [3:0] nib[$];
    logic tk;
    nib = {NIB_PRE, NIB_PRE};
    for (int i = 0; i < cnt; i++) begin
      nib.push_back(4'($urandom));
      exp_q.push_back(nib[i + 2]);
    end
    tx_en = 1'b1;
    txd = nib[0];
    tk = tx_ready;
    while (nib.size() > 0) begin
      @(negedge clock);
      if (tk) begin
        void'(nib.pop_front());
        if (nib.size() > 0) begin
          txd = nib[0];
        end
      end
      tk = tx_ready;
    end
    tx_en = 1'b0;
  endtask

  task automatic wait_quiet();
    int t;
    t = 0;
    while (t < 40) begin
      @(negedge clock);
      t = rx_dv ? 0 : t + 1;
    end
  endtask

  // edges of the receive clock seen over 100 cycles
  task automatic clk_toggles(output int cnt);
    logic last;
    cnt = 0;
    last = rx_clk;
    repeat (100) begin
      @(negedge clock);
      cnt += int'(rx_clk !== last);
      last = rx_clk;
    end
  endtask

  initial begin
    rst = 1'b1;
    speed = SPD_100;
    rgmii_mode = 1'b0;
    gig_slave = 1'b0;
    ldo_disable = 1'b0;
    tx_en = 1'b0;
    txd = 4'h0;
    mlt_on = 1'b1;
    err_count = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(46463));
    repeat (2) @(negedge clock);
    check({7'h00, ldo_ctrl_en}, 8'h01, "reset regulator");
    check({7'h00, rx_dv}, 8'h00, "reset valid");
    @(negedge clock);
    rst = 1'b0;
    repeat (100) @(negedge clock);
    n = 0;
    repeat (50) begin
      @(negedge clock);
      n += int'(tx_ready);
    end
    check(8'(n), 8'h0A, "ready rate");
    for (int f = 0; f < 3; f++) begin
      rgmii_mode = 1'($urandom);
      send100(f == 0 ? 1 : 4 + $urandom % 9);
      wait_quiet();
      check(8'(exp_q.size()), 8'h00, "nibbles lost");
      $display("test frame100 %0d done", f);
    end
    clk_toggles(n);
    check(8'(n), 8'h64, "recovered rx clock");
    speed = SPD_10;
    repeat (60) @(negedge clock);
    clk_toggles(n);
    check({7'h00, n >= 10}, 8'h01, "idle rx clock");
    check({6'h00, tx_mlt3}, 8'h00, "line quiet at 10M");
    for (int f = 0; f < 2; f++) begin
      d = (f == 0) ? 32'h55D52A55 : $urandom;
      rgmii_mode = 1'($urandom);
      exp_q.push_back(NIB_SFD_HI);
      for (int i = 0; i < 8; i++) begin
        exp_q.push_back(d[4 * i +: 4]);
      end
      link_partner_i.send10(d, f[0]);
      wait_quiet();
      check(8'(exp_q.size()), 8'h00, "nibbles lost");
      $display("test frame10 %0d done", f);
    end
    mlt_on = 1'b0;
    for (int i = 0; i < 12; i++) begin
      speed = speed_t'(i % 3);
      gig_slave = 1'($urandom);
      ldo_disable = 1'($urandom);
      repeat (2) @(negedge clock);
      check({7'h00, hybrid_en}, {7'h00, speed == SPD_1000}, "hybrid");
      check({7'h00, adc_en}, {7'h00, speed == SPD_1000}, "adc");
      check({7'h00, tx_clk_from_rx}, {7'h00, speed == SPD_1000 && gig_slave}, "slave timing");
      check({7'h00, ldo_ctrl_en}, {7'h00, !ldo_disable}, "regulator");
    end
    $display("test static controls done");
    summarize();
  end
endmodule // tb_top
